// ### design/ubg_uart_tx.sv
// Notes on behaviour
// RULE1: baud generator is an 8-bit free-running reload timer set by baud_divisor.
// RULE2: rate is osc/(64(d+1)), osc/(16(d+1)) high speed, osc/(4(d+1)) synchronous.
// RULE3: the rate formulas hold only when the port makes its own clock.
// RULE4: any baud_divisor write restarts the baud timer at once.
// RULE5: receive level is a majority of three samples mid bit.
// RULE6: frames are NRZ: start bit, eight or nine data bits, stop bit.
// RULE7: data goes out least significant bit first.
// RULE8: transmitter and receiver share one format setting and one baud rate.
// RULE9: generator output is x16 with high speed select, else x64.
// RULE10: no hardware parity; software puts parity in the ninth bit.
// RULE11: asynchronous operation halts during sleep.
// RULE12: mode select bit 4 clear selects asynchronous operation.
// RULE13: shift register reloads only after the stop bit, from holding if loaded.
// RULE14: holding to shift move takes one cycle, empties holding, sets transmit_flag.
// RULE15: transmit_flag ignores enables, software cannot clear it, holding write clears.
// RULE16: setting transmit_enable sets transmit_flag; the code sets it only while holding is empty.
// RULE17: read-only bit 1 shows shift register empty; raises no interrupt.
// RULE18: the shift register has no address.
// RULE19: sending starts with enable set, holding loaded and a shift clock tick.
// RULE20: clearing transmit_enable aborts the frame and releases the pin.
// RULE21: software writes nine_bit_select and ninth_data_bit before the data byte.
// RULE22: software sets divisor, mode, port enable, format, enable, then data.
// RULE23: serial_port_enable hands both pins to the serial function.
// RULE24: line idles high; start bit low, stop bit high.
`timescale 1ns/10ps
`default_nettype none

module ubg_uart_tx #(
  parameter int unsigned DIV_W = 8
) (
  input  wire logic                          core_clk,
  input  wire logic                          arst_n,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [ubg_pkg::UBG_ADDR_W-1:0] paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          sleep_hold,
  input  wire logic                          rx_in,
  output logic                               rx_level,
  output logic                               tx_out,
  output logic                               tx_oe_n
);
  import ubg_pkg::*;

  typedef struct packed {
    logic [7:0]       intctl;
    logic [7:0]       pien;
    logic             txf;
    logic             csrc;
    logic             tx9;
    logic             transmit_enable;
    logic             sync;
    logic             high_speed_select;
    logic             ninth_data_bit;
    logic             serial_port_enable;
    logic             rx9;
    logic             sren;
    logic             cren;
    logic [7:0]       hold;
    logic             hold_full;
    logic [DIV_W-1:0] div;
    logic [DIV_W-1:0] tmr;
    logic [5:0]       ovs;
    logic [1:0]       smp;
    logic             rxl;
    ubg_tx_state_t    st;
    logic [8:0]       shf;
    logic [3:0]       bitn;
    logic             txo;
    logic             oe_n;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
  } ubg_state_t;

  ubg_state_t s_r;
  ubg_state_t s_nxt;

  logic [UBG_IDX_W-1:0] idx;
  logic                 mapped;
  logic                 wr_acc;
  logic                 hold_wr;
  logic                 div_wr;
  logic                 transmit_enable_rise;
  logic                 run;
  logic                 os_tick;
  logic                 bit_tick;
  logic                 active;
  logic                 load_ok;
  logic [5:0]           ratio_m1;
  logic [5:0]           mid;
  logic [3:0]           last_bit;
  logic [7:0]           rd_val;

  // address decode; the shift register is deliberately absent
  always_comb begin
    idx = paddr[UBG_ADDR_W-1:2];
    // RULE18 shift unmapped
    mapped = (paddr[1:0] == 2'b00) &&
             (idx == UBG_IDX_INTCTL || idx == UBG_IDX_PIFLG || idx == UBG_IDX_RCSTC ||
              idx == UBG_IDX_HOLD   || idx == UBG_IDX_LINE  || idx == UBG_IDX_PIEN  ||
              idx == UBG_IDX_TXSTC  || idx == UBG_IDX_BDIV);
  end

  // apb strobes and rate selection
  always_comb begin
    wr_acc    = psel && penable && s_r.pready && pwrite && mapped;
    hold_wr   = wr_acc && (idx == UBG_IDX_HOLD);
    div_wr    = wr_acc && (idx == UBG_IDX_BDIV);
    transmit_enable_rise = wr_acc && (idx == UBG_IDX_TXSTC) && pwdata[UBG_TX_EN_B] && !s_r.transmit_enable;
    // RULE11 sleep freezes
    run       = !sleep_hold;
    // RULE2 ratio per mode
    // RULE9 x16 or x64
    ratio_m1  = s_r.sync ? UBG_RATIO_SYNC : (s_r.high_speed_select ? UBG_RATIO_HIGH : UBG_RATIO_LOW);
    mid       = 6'((7'(ratio_m1) + 7'h01) >> 1);
    // RULE1 timer overflow tick
    os_tick   = run && (s_r.tmr == '0) && !div_wr;
    // RULE3 internal clock only
    bit_tick  = os_tick && (s_r.ovs >= ratio_m1) && (!s_r.sync || s_r.csrc);
    // RULE12 asynchronous only
    // RULE23 pins need port enable
    active    = s_r.serial_port_enable && s_r.transmit_enable && !s_r.sync;
    load_ok   = s_r.hold_full && !hold_wr && run;
    // RULE6 eight or nine bits
    // RULE10 ninth bit is plain data
    last_bit  = s_r.tx9 ? UBG_LAST_BIT9 : UBG_LAST_BIT8;
  end

  // read data mux
  always_comb begin
    rd_val = UBG_RST_REG8;
    unique case (idx)
      UBG_IDX_INTCTL: rd_val = s_r.intctl;
      UBG_IDX_PIFLG:  rd_val[UBG_FLG_TX_B] = s_r.txf;
      UBG_IDX_RCSTC: begin
        rd_val[UBG_RC_SERIAL_PORT_ENABLE_B] = s_r.serial_port_enable;
        rd_val[UBG_RC_RX9_B]  = s_r.rx9;
        rd_val[UBG_RC_SREN_B] = s_r.sren;
        rd_val[UBG_RC_CREN_B] = s_r.cren;
      end
      UBG_IDX_HOLD:   rd_val = s_r.hold;
      UBG_IDX_LINE:   rd_val[0] = s_r.rxl;
      UBG_IDX_PIEN:   rd_val = s_r.pien;
      UBG_IDX_TXSTC: begin
        rd_val[UBG_TX_CSRC_B] = s_r.csrc;
        rd_val[UBG_TX_NINE_B] = s_r.tx9;
        rd_val[UBG_TX_EN_B]   = s_r.transmit_enable;
        rd_val[UBG_TX_SYNC_B] = s_r.sync;
        rd_val[UBG_TX_HS_B]   = s_r.high_speed_select;
        // RULE17 shift empty status
        rd_val[UBG_TX_EMPT_B] = (s_r.st == UBG_ST_IDLE);
        rd_val[UBG_TX_D9_B]   = s_r.ninth_data_bit;
      end
      UBG_IDX_BDIV:   rd_val = 8'(s_r.div);
      default:        rd_val = UBG_RST_REG8;
    endcase
  end

  // next state of the whole block
  always_comb begin
    s_nxt = s_r;

    // apb slave: one wait-free access phase, data captured at setup
    s_nxt.pready  = psel && !penable;
    s_nxt.pslverr = psel && !penable && !mapped;
    if (psel && !penable) begin
      s_nxt.prdata = {24'h000000, rd_val};
    end

    // register writes; the flag register ignores software
    if (wr_acc) begin
      unique case (idx)
        UBG_IDX_INTCTL: s_nxt.intctl = pwdata[7:0];
        UBG_IDX_PIEN:   s_nxt.pien   = pwdata[7:0];
        UBG_IDX_RCSTC: begin
          s_nxt.serial_port_enable = pwdata[UBG_RC_SERIAL_PORT_ENABLE_B];
          s_nxt.rx9  = pwdata[UBG_RC_RX9_B];
          s_nxt.sren = pwdata[UBG_RC_SREN_B];
          s_nxt.cren = pwdata[UBG_RC_CREN_B];
        end
        UBG_IDX_TXSTC: begin
          s_nxt.csrc = pwdata[UBG_TX_CSRC_B];
          s_nxt.tx9  = pwdata[UBG_TX_NINE_B];
          s_nxt.transmit_enable = pwdata[UBG_TX_EN_B];
          s_nxt.sync = pwdata[UBG_TX_SYNC_B];
          s_nxt.high_speed_select = pwdata[UBG_TX_HS_B];
          s_nxt.ninth_data_bit = pwdata[UBG_TX_D9_B];
        end
        default: ;
      endcase
    end

    // baud timer and oversample counter
    if (div_wr) begin
      // RULE4 restart on write
      s_nxt.div = pwdata[DIV_W-1:0];
      s_nxt.tmr = pwdata[DIV_W-1:0];
      s_nxt.ovs = '0;
    end else if (run) begin
      // RULE1 free-running reload
      s_nxt.tmr = (s_r.tmr == '0) ? s_r.div : s_r.tmr - 1'b1;
      if (os_tick) begin
        s_nxt.ovs = (s_r.ovs >= ratio_m1) ? 6'h00 : s_r.ovs + 6'h01;
      end
    end

    // three samples around mid bit, majority vote on the third
    // RULE8 shared baud rate
    if (os_tick && s_r.serial_port_enable) begin
      // RULE5 majority of three
      if (s_r.ovs == mid - 6'h01) begin
        s_nxt.smp[0] = rx_in;
      end else if (s_r.ovs == mid) begin
        s_nxt.smp[1] = rx_in;
      end else if (s_r.ovs == mid + 6'h01) begin
        s_nxt.rxl = (s_r.smp[0] & s_r.smp[1]) | (s_r.smp[0] & rx_in) | (s_r.smp[1] & rx_in);
      end
    end

    // transmitter
    if (!active) begin
      // RULE20 abort and release pin
      s_nxt.st   = UBG_ST_IDLE;
      s_nxt.txo  = 1'b1;
      s_nxt.oe_n = 1'b1;
      s_nxt.bitn = 4'h0;
    end else begin
      s_nxt.oe_n = 1'b0;
      unique case (s_r.st)
        UBG_ST_IDLE: begin
          // RULE24 idle high
          s_nxt.txo = 1'b1;
          if (load_ok) begin
            // RULE14 one-cycle move
            s_nxt.shf       = {s_r.ninth_data_bit, s_r.hold};
            s_nxt.hold_full = 1'b0;
            s_nxt.txf       = 1'b1;
            s_nxt.st        = UBG_ST_WAIT;
          end
        end
        UBG_ST_WAIT: begin
          // RULE19 start on shift clock
          if (bit_tick) begin
            s_nxt.txo = 1'b0;
            s_nxt.st  = UBG_ST_START;
          end
        end
        UBG_ST_START: begin
          if (bit_tick) begin
            // RULE7 lsb first
            s_nxt.txo  = s_r.shf[0];
            s_nxt.shf  = {1'b0, s_r.shf[8:1]};
            s_nxt.bitn = 4'h0;
            s_nxt.st   = UBG_ST_DATA;
          end
        end
        UBG_ST_DATA: begin
          if (bit_tick) begin
            if (s_r.bitn == last_bit) begin
              // RULE24 stop bit high
              s_nxt.txo = 1'b1;
              s_nxt.st  = UBG_ST_STOP;
            end else begin
              s_nxt.txo  = s_r.shf[0];
              s_nxt.shf  = {1'b0, s_r.shf[8:1]};
              s_nxt.bitn = s_r.bitn + 4'h1;
            end
          end
        end
        UBG_ST_STOP: begin
          if (bit_tick) begin
            // RULE13 reload after stop
            if (load_ok) begin
              s_nxt.shf       = {s_r.ninth_data_bit, s_r.hold};
              s_nxt.hold_full = 1'b0;
              s_nxt.txf       = 1'b1;
              s_nxt.txo       = 1'b0;
              s_nxt.st        = UBG_ST_START;
            end else begin
              s_nxt.txo = 1'b1;
              s_nxt.st  = UBG_ST_IDLE;
            end
          end
        end
      endcase
    end

    // RULE16 enable sets flag
    if (transmit_enable_rise && !hold_wr && !s_r.hold_full) begin
      s_nxt.txf = 1'b1;
    end

    // RULE15 only a holding write clears the flag
    if (hold_wr) begin
      s_nxt.hold      = pwdata[7:0];
      s_nxt.hold_full = 1'b1;
      s_nxt.txf       = 1'b0;
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r           <= '0;
      s_r.intctl    <= UBG_RST_REG8;
      s_r.pien      <= UBG_RST_REG8;
      s_r.hold      <= UBG_RST_REG8;
      s_r.rxl       <= UBG_RST_LINE;
      s_r.smp       <= {UBG_RST_LINE, UBG_RST_LINE};
      s_r.st        <= UBG_ST_IDLE;
      s_r.txo       <= 1'b1;
      s_r.oe_n      <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs straight from the state register
  assign prdata   = s_r.prdata;
  assign pready   = s_r.pready;
  assign pslverr  = s_r.pslverr;
  assign rx_level = s_r.rxl;
  assign tx_out   = s_r.txo;
  assign tx_oe_n  = s_r.oe_n;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  a_div_write_restart: assert property ( // RULE4
    div_wr |=> (s_r.tmr == s_r.div) && (s_r.ovs == 6'h00))
    else $error("divisor write did not restart the timer");

  a_sleep_timer_hold: assert property ( // RULE11
    sleep_hold && !div_wr |=> $stable(s_r.tmr) && $stable(s_r.ovs) && $stable(s_r.st))
    else $error("timer or transmitter moved during sleep");

  a_start_needs_tick: assert property ( // RULE19
    (s_r.st == UBG_ST_WAIT) && active && !bit_tick |=> s_r.st == UBG_ST_WAIT)
    else $error("frame started without a shift clock");

  a_start_bit_low: assert property ( // RULE24
    (s_r.st == UBG_ST_START) |-> !tx_out && !tx_oe_n)
    else $error("start bit not driven low");

  a_stop_bit_high: assert property ( // RULE24
    (s_r.st == UBG_ST_STOP) |-> tx_out)
    else $error("stop bit not high");

  a_abort_release: assert property ( // RULE20
    active && wr_acc && (idx == UBG_IDX_TXSTC) && !pwdata[UBG_TX_EN_B]
      |=> ##1 tx_oe_n && (s_r.st == UBG_ST_IDLE))
    else $error("clearing enable did not release the pin");

  a_transfer_sets_flag: assert property ( // RULE14
    active && (s_r.st == UBG_ST_IDLE) && load_ok |=> s_r.txf && !s_r.hold_full)
    else $error("holding move did not set the flag");

  a_write_clears_flag: assert property ( // RULE15
    hold_wr |=> !s_r.txf && s_r.hold_full)
    else $error("holding write did not clear the flag");

  a_enable_sets_flag: assert property ( // RULE16
    transmit_enable_rise && !hold_wr && !s_r.hold_full |=> s_r.txf)
    else $error("enable did not set the flag");

  a_lsb_first: assert property ( // RULE7
    (s_r.st == UBG_ST_START) && bit_tick && active |=> tx_out == $past(s_r.shf[0]))
    else $error("first data bit is not the lsb");

  a_pins_need_serial_port_enable: assert property ( // RULE23
    !s_r.serial_port_enable |=> tx_oe_n)
    else $error("pin driven without port enable");

  c_frame_sent: cover property ((s_r.st == UBG_ST_STOP) ##1 (s_r.st == UBG_ST_IDLE));
  c_back_to_back: cover property ((s_r.st == UBG_ST_STOP) ##1 (s_r.st == UBG_ST_START));
  c_nine_bit: cover property ((s_r.st == UBG_ST_DATA) && s_r.tx9 && (s_r.bitn == UBG_LAST_BIT9));
  c_abort: cover property ((s_r.st == UBG_ST_DATA) ##1 !active);

endmodule

`default_nettype wire

// ### design/ubg_pkg.sv
// shared constants of the baud generator and asynchronous transmitter
package ubg_pkg;

  // apb address width in bits; registers sit at byte address = 4 * index
  localparam int unsigned UBG_ADDR_W   = 12;
  localparam int unsigned UBG_IDX_W    = UBG_ADDR_W - 2;

  // register indices
  localparam logic [UBG_IDX_W-1:0] UBG_IDX_INTCTL = 10'h00B; // interrupt_control
  localparam logic [UBG_IDX_W-1:0] UBG_IDX_PIFLG  = 10'h00C; // peripheral_interrupt_flags
  localparam logic [UBG_IDX_W-1:0] UBG_IDX_RCSTC  = 10'h018; // receive_status_control
  localparam logic [UBG_IDX_W-1:0] UBG_IDX_HOLD   = 10'h019; // transmit_holding
  localparam logic [UBG_IDX_W-1:0] UBG_IDX_LINE   = 10'h020; // line status (receive level)
  localparam logic [UBG_IDX_W-1:0] UBG_IDX_PIEN   = 10'h08C; // peripheral_interrupt_enables
  localparam logic [UBG_IDX_W-1:0] UBG_IDX_TXSTC  = 10'h098; // transmit_status_control
  localparam logic [UBG_IDX_W-1:0] UBG_IDX_BDIV   = 10'h099; // baud_divisor

  // transmit_status_control bit positions
  localparam int unsigned UBG_TX_CSRC_B = 7;
  localparam int unsigned UBG_TX_NINE_B = 6;
  localparam int unsigned UBG_TX_EN_B   = 5;
  localparam int unsigned UBG_TX_SYNC_B = 4;
  localparam int unsigned UBG_TX_HS_B   = 2;
  localparam int unsigned UBG_TX_EMPT_B = 1;
  localparam int unsigned UBG_TX_D9_B   = 0;

  // receive_status_control and flag bit positions
  localparam int unsigned UBG_RC_SERIAL_PORT_ENABLE_B = 7;
  localparam int unsigned UBG_RC_RX9_B  = 6;
  localparam int unsigned UBG_RC_SREN_B = 5;
  localparam int unsigned UBG_RC_CREN_B = 4;
  localparam int unsigned UBG_FLG_TX_B  = 4;

  // reset values
  localparam logic [7:0] UBG_RST_REG8 = 8'h00;
  localparam logic       UBG_RST_LINE = 1'h1;

  // oversample ratio minus one per mode
  localparam logic [5:0] UBG_RATIO_LOW  = 6'h3F; // x64
  localparam logic [5:0] UBG_RATIO_HIGH = 6'h0F; // x16
  localparam logic [5:0] UBG_RATIO_SYNC = 6'h03; // x4

  // index of the last data bit
  localparam logic [3:0] UBG_LAST_BIT8 = 4'h7;
  localparam logic [3:0] UBG_LAST_BIT9 = 4'h8;

  // transmitter states, one-hot
  typedef enum logic [4:0] {
    UBG_ST_IDLE  = 5'h01,
    UBG_ST_WAIT  = 5'h02,
    UBG_ST_START = 5'h04,
    UBG_ST_DATA  = 5'h08,
    UBG_ST_STOP  = 5'h10
  } ubg_tx_state_t;

endpackage

// ### verif/ubg_rx_model.sv
`timescale 1ns/10ps
`default_nettype none

// remote receiver on the transmit line; samples each bit at its middle
module ubg_rx_model (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        line,
  input  wire logic        oe_n,
  input  wire logic        nine,
  input  wire logic [15:0] bit_cycles,
  output logic             fr_vld,
  output logic [8:0]       fr_data,
  output logic             fr_err
);
  int         cnt;
  int         bitn;
  logic       busy;
  logic       bad;
  logic [8:0] sh;

  // frame capture, abandoned when the pin is released
  always @(posedge core_clk or negedge arst_n) begin
    fr_vld <= 1'b0;
    if (!arst_n || oe_n) begin
      busy = 1'b0;
    end else if (!busy) begin
      if (!line) begin
        busy = 1'b1;
        cnt = 0;
        bitn = 0;
        sh = 9'h000;
      end
    end else begin
      cnt++;
      if (cnt == int'(bit_cycles) / 2) begin
        if (bitn == 0) begin
          bad = line;
        end else if (bitn <= (nine ? 9 : 8)) begin
          sh[bitn-1] = line;
        end else begin
          fr_vld  <= 1'b1;
          fr_data <= sh;
          fr_err  <= bad | ~line;
          busy = 1'b0;
        end
        bitn++;
      end
      if (cnt == int'(bit_cycles)) begin
        cnt = 0;
      end
    end
  end
endmodule

`default_nettype wire

// ### verif/test_uart_baud_gen_async_tx.sv
`timescale 1ns/10ps
`default_nettype none

module test_uart_baud_gen_async_tx;
  import ubg_pkg::*;
  logic                  core_clk;
  logic                  arst_n;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [UBG_ADDR_W-1:0] paddr;
  logic [31:0]           pwdata;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  sleep_hold;
  logic                  rx_in;
  logic                  rx_level;
  logic                  tx_out;
  logic                  tx_oe_n;
  wire logic             tx_line;
  logic                  nine;
  logic [15:0]           bit_cycles;
  logic                  fr_vld;
  logic [8:0]            fr_data;
  logic                  fr_err;
  logic [32:0]           rdq[$];
  logic [9:0]            frq[$];
  int                    failures;
  int                    n_tests;
  int                    lo_n;
  integer                seed;
  logic [7:0]            r;

  // pin with pull-up: released line reads high
  assign tx_line = tx_oe_n ? 1'b1 : tx_out;

  ubg_uart_tx u_ubg_uart_tx (.core_clk(core_clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleep_hold(sleep_hold), .rx_in(rx_in),
    .rx_level(rx_level), .tx_out(tx_out), .tx_oe_n(tx_oe_n));

  ubg_rx_model u_ubg_rx_model (.core_clk(core_clk), .arst_n(arst_n), .line(tx_line),
    .oe_n(tx_oe_n), .nine(nine), .bit_cycles(bit_cycles), .fr_vld(fr_vld),
    .fr_data(fr_data), .fr_err(fr_err));

  // clock, 100 ns period
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("checks=%0d mismatches=%0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // one apb transfer; a read notes its expected {pslverr, prdata}
  task automatic apb(input logic w, input logic [UBG_ADDR_W-1:0] a, input logic [7:0] d,
                     input logic [32:0] exp);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    if (!w) rdq.push_back(exp);
    @(posedge core_clk);
    penable <= 1'b1;
    // only the watchdog ends a wait for the answer
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [UBG_IDX_W-1:0] i, input logic [7:0] d);
    apb(1'b1, {i, 2'b00}, d, 33'h0);
  endtask

  task automatic rd(input logic [UBG_IDX_W-1:0] i, input logic [7:0] e);
    apb(1'b0, {i, 2'b00}, 8'h00, {25'h0, e});
  endtask

  // ninth bit is set beforehand by the caller, then the byte
  task automatic send(input logic d9, input logic [7:0] d);
    frq.push_back({1'b0, d9 & nine, d});
    wr(UBG_IDX_HOLD, d);
  endtask

  task automatic drain;
    while (frq.size() != 0) begin
      @(posedge core_clk);
    end
    repeat (int'(bit_cycles) + 4) @(posedge core_clk);
  endtask

  // cycles the line stays low, from its next falling edge on
  task automatic low_run(output int n);
    n = 0;
    while (tx_line !== 1'b0) @(posedge core_clk);
    while (tx_line === 1'b0) begin
      @(posedge core_clk);
      n++;
    end
  endtask

  // result watcher: oldest note against each answer
  always @(posedge core_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (rdq.size() == 0) chk(64'h1, 64'h0);
      else chk({pslverr, prdata}, rdq.pop_front());
    end
    if (fr_vld === 1'b1) begin
      if (frq.size() == 0) chk(64'h1, 64'h0);
      else chk({fr_err, fr_data}, frq.pop_front());
    end
  end

  initial begin
    repeat (60000) @(posedge core_clk);
    failures++;
    results();
  end

  initial begin
    seed = 32'hBBB590F1;
    {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {sleep_hold, nine} = 2'b00;
    rx_in = 1'b1;
    bit_cycles = 16'h0010;
    repeat (10) @(posedge core_clk);
    arst_n <= 1'b1;
    rd(UBG_IDX_TXSTC, 8'h02);
    rd(UBG_IDX_BDIV, 8'h00);
    rd(UBG_IDX_PIFLG, 8'h00);
    apb(1'b0, 12'hFFC, 8'h00, 33'h100000000);
    apb(1'b0, 12'h266, 8'h00, 33'h100000000);
    // pin stays released while the port is off
    #1 chk(tx_oe_n, 1'b1);
    $display("test reset done");
    // setup order, x16 with divisor 0
    wr(UBG_IDX_BDIV, 8'h00);
    wr(UBG_IDX_RCSTC, 8'h80);
    wr(UBG_IDX_TXSTC, 8'h24);
    rd(UBG_IDX_PIFLG, 8'h10);
    rd(UBG_IDX_TXSTC, 8'h26);
    wr(UBG_IDX_PIFLG, 8'h00);
    rd(UBG_IDX_PIFLG, 8'h10);
    // enables are plain storage and leave the flag alone
    r = 8'($random(seed));
    wr(UBG_IDX_PIEN, r);
    rd(UBG_IDX_PIEN, r);
    rd(UBG_IDX_PIFLG, 8'h10);
    rd(UBG_IDX_RCSTC, 8'h80);
    // majority level of the receive pin
    rx_in <= 1'b0;
    repeat (100) @(posedge core_clk);
    rd(UBG_IDX_LINE, 8'h00);
    #1 chk(rx_level, 1'b0);
    rx_in <= 1'b1;
    repeat (100) @(posedge core_clk);
    rd(UBG_IDX_LINE, 8'h01);
    // single-cycle glitches, at least three cycles apart, are outvoted
    for (int i = 0; i < 8; i++) begin
      r = 8'($random(seed));
      repeat (int'(r[3:0]) + 3) @(posedge core_clk);
      rx_in <= 1'b0;
      @(posedge core_clk);
      rx_in <= 1'b1;
    end
    repeat (40) @(posedge core_clk);
    rd(UBG_IDX_LINE, 8'h01);
    #1 chk(rx_level, 1'b1);
    $display("test setup done");
    send(1'b0, 8'h3C);
    send(1'b0, 8'hC5);
    rd(UBG_IDX_PIFLG, 8'h00);
    rd(UBG_IDX_TXSTC, 8'h24);
    drain();
    rd(UBG_IDX_PIFLG, 8'h10);
    rd(UBG_IDX_TXSTC, 8'h26);
    // start bit plus a low lsb last two bit times of 16 cycles
    send(1'b0, 8'hFE);
    low_run(lo_n);
    chk(lo_n, 32);
    drain();
    for (int i = 0; i < 3; i++) begin
      r = 8'($random(seed));
      send(1'b0, r);
      drain();
    end
    $display("test frames done");
    // nine-bit frames carry software's ninth bit
    nine = 1'b1;
    for (int i = 0; i < 2; i++) begin
      wr(UBG_IDX_TXSTC, i == 0 ? 8'h65 : 8'h64);
      r = 8'($random(seed));
      send(i == 0, r);
      drain();
    end
    nine = 1'b0;
    wr(UBG_IDX_TXSTC, 8'h24);
    $display("test nine done");
    sleep_hold <= 1'b1;
    send(1'b0, 8'h81);
    repeat (100) @(posedge core_clk);
    #1 chk(tx_line, 1'b1);
    @(posedge core_clk);
    sleep_hold <= 1'b0;
    drain();
    // synchronous mode sends nothing; byte goes once async
    wr(UBG_IDX_TXSTC, 8'h34);
    wr(UBG_IDX_HOLD, 8'hA5);
    repeat (60) @(posedge core_clk);
    #1 chk(tx_oe_n, 1'b1);
    frq.push_back(10'h0A5);
    wr(UBG_IDX_TXSTC, 8'h24);
    drain();
    $display("test modes done");
    wr(UBG_IDX_HOLD, 8'h0F);
    while (tx_line !== 1'b0) @(posedge core_clk);
    repeat (30) @(posedge core_clk);
    wr(UBG_IDX_TXSTC, 8'h04);
    repeat (2) @(posedge core_clk);
    #1 chk(tx_oe_n, 1'b1);
    rd(UBG_IDX_TXSTC, 8'h06);
    $display("test abort done");
    wr(UBG_IDX_BDIV, 8'h01);
    bit_cycles = 16'h0080;
    wr(UBG_IDX_TXSTC, 8'h20);
    r = 8'($random(seed));
    send(1'b0, r);
    drain();
    chk(frq.size(), 0);
    // two low bit times of 128 cycles at x64 with divisor 1
    send(1'b0, 8'hFE);
    low_run(lo_n);
    chk(lo_n, 256);
    drain();
    #1 chk(tx_oe_n, 1'b0);
    // dropping the port enable releases the pin even while enabled
    wr(UBG_IDX_RCSTC, 8'h00);
    repeat (2) @(posedge core_clk);
    #1 chk(tx_oe_n, 1'b1);
    $display("test low speed done");
    results();
  end
endmodule

`default_nettype wire
